// *** bench/format_unit_command_handler_tb_top.sv ***
// testbench: both ends joined, driven over avalon-mm and unit-state inputs
module format_unit_command_handler_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 16;
  logic        mclk, rst_n, avs_read, avs_write, avs_waitrequest, irq;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, seed_q, q, cert_addr;
  logic        unit_reserved, extent_reserved, cert_defect, format_done, format_fail, format_busy;
  logic [15:0] progress;
  logic [7:0]  defect_count, st, op;
  logic [7:0]  pl[$];
  logic [2:0]  dlfs[3];
  int          failures, checks, stat_cnt, exp_cnt;
  fuch_if lnk_if ();
  fuch_target #(.DEPTH(DEPTH)) fuch_target_i (.mclk(mclk), .rst_n(rst_n), .lnk(lnk_if),
    .unit_reserved(unit_reserved), .extent_reserved(extent_reserved), .cert_defect(cert_defect),
    .cert_addr(cert_addr), .format_done(format_done), .format_fail(format_fail),
    .format_busy(format_busy), .progress(progress), .defect_count(defect_count));
  fuch_initiator fuch_initiator_i (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .lnk(lnk_if));
  fuch_checker #(.DEPTH(DEPTH)) fuch_checker_i (.mclk(mclk), .rst_n(rst_n),
    .cmd_valid(lnk_if.cmd_valid), .cmd_byte(lnk_if.cmd_byte), .cmd_ready(lnk_if.cmd_ready),
    .dout_req(lnk_if.dout_req), .din_valid(lnk_if.din_valid), .din_byte(lnk_if.din_byte),
    .stat_valid(lnk_if.stat_valid), .stat_byte(lnk_if.stat_byte), .unit_reserved(unit_reserved),
    .extent_reserved(extent_reserved), .cert_defect(cert_defect), .format_done(format_done),
    .format_fail(format_fail), .format_busy(format_busy), .defect_count(defect_count));
  always #5 mclk = ~mclk;
  always @(posedge mclk) if (lnk_if.stat_valid === 1'b1) stat_cnt++;
  // ==========================================
  // helpers
  function automatic logic [7:0] rnd8();
    seed_q ^= seed_q << 13;
    seed_q ^= seed_q >> 17;
    seed_q ^= seed_q << 5;
    return seed_q[7:0];
  endfunction : rnd8
  function automatic int next_count(input logic cmpl, input int old, input int n);
    return cmpl ? n : old + n;
  endfunction : next_count
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check8
  task automatic check1(input logic got, input logic exp, input string what);
    check8({7'h0, got}, {7'h0, exp}, what);
  endtask : check1
  // request held until waitrequest is sampled low; one idle edge keeps drives apart
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (avs_waitrequest !== 1'b0) begin
      failures++;
      $display("[FAIL] %0t bus request not answered", $time);
    end
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask : bus
  task automatic build_list(input logic [7:0] opts, input int nd);
    pl = '{8'h00, opts, 8'h00, 8'(nd * 8)};
    if (opts[fuch_pkg::H_INIT_PAT]) repeat (4) pl.push_back(rnd8());
    repeat (nd * 8) pl.push_back(rnd8());
  endtask : build_list
  task automatic run_cmd(input logic [7:0] c0, input logic [7:0] c1);
    int n, s;
    logic [31:0] r;
    for (int i = 0; i < 6; i++) begin
      logic [7:0] b;
      b = (i == 0) ? c0 : (i == 1) ? c1 : (i == 5) ? 8'h00 : rnd8();
      bus(1'b1, fuch_pkg::A_CDB, {21'h0, 3'(i), b}, r);
    end
    s = stat_cnt;
    bus(1'b1, fuch_pkg::A_CTRL, 32'h1, r);
    foreach (pl[i]) begin
      n = 0;
      do begin
        bus(1'b0, fuch_pkg::A_STAT, 32'h0, r);
        n++;
      end while (r[8] !== 1'b0 && n < 200);
      check1(r[8], 1'b0, "parameter byte taken");
      bus(1'b1, fuch_pkg::A_DOUT, {24'h0, pl[i]}, r);
    end
    n = 0;
    while (stat_cnt == s && n < 500) begin
      @(posedge mclk);
      n++;
    end
    check1(n < 500, 1'b1, "status arrives");
    bus(1'b0, fuch_pkg::A_STAT, 32'h0, r);
    st = r[7:0];
    pl.delete();
  endtask : run_cmd
  task automatic end_fmt(input logic fail);
    format_done <= !fail;
    format_fail <= fail;
    @(posedge mclk);
    format_done <= 1'b0;
    format_fail <= 1'b0;
    @(posedge mclk);
    check1(format_busy, 1'b0, "busy clear");
  endtask : end_fmt
  task automatic sense_key(input logic [3:0] exp);
    run_cmd(fuch_pkg::OP_REQ_SENSE, 8'h00);
    bus(1'b0, fuch_pkg::A_SENSE, 32'h0, q);
    check8({4'h0, q[7:4]}, {4'h0, exp}, "sense key");
  endtask : sense_key
  // ==========================================
  // watchdog: the whole sequence needs well under 20000 cycles
  initial begin
    repeat (60000) @(posedge mclk);
    failures++;
    report_and_stop();
  end
  initial begin
    {mclk, rst_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
    {unit_reserved, extent_reserved, cert_defect, format_done, format_fail, cert_addr} = '0;
    {failures, checks, stat_cnt, exp_cnt} = '0;
    seed_q = 32'hCE5A0D07;
    dlfs = '{fuch_pkg::DLF_BLOCK, fuch_pkg::DLF_BFI, fuch_pkg::DLF_PHYS};
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    bus(1'b0, fuch_pkg::A_STAT, 32'h0, q);
    check8(q[7:0], 8'h00, "stat reset");
    bus(1'b0, 4'hF, 32'h0, q);
    check8(q[7:0], 8'h00, "unmapped read");
    check1(irq, 1'b0, "irq reset");
    check1(format_busy, 1'b0, "busy reset");
    $display("test reset done");
    unit_reserved <= 1'b1;
    run_cmd(fuch_pkg::OP_FORMAT, 8'h08);
    check8(st, fuch_pkg::ST_RESV, "unit reserved");
    unit_reserved <= 1'b0;
    extent_reserved <= 1'b1;
    run_cmd(fuch_pkg::OP_FORMAT, 8'h08);
    check8(st, fuch_pkg::ST_RESV, "extent reserved");
    check1(format_busy, 1'b0, "busy after refusal");
    extent_reserved <= 1'b0;
    $display("test reservation done");
    run_cmd(fuch_pkg::OP_FORMAT, 8'h08);
    check8(st, fuch_pkg::ST_GOOD, "format accepted");
    check1(format_busy, 1'b1, "busy set");
    check8(defect_count, 8'h00, "complete list clears");
    for (int i = 0; i < 4; i++) begin
      op = rnd8();
      if (op == fuch_pkg::OP_REQ_SENSE || op == fuch_pkg::OP_INQUIRY) op ^= 8'h40;
      unit_reserved <= (i == 3);
      run_cmd(op, 8'h00);
      check8(st, (i == 3) ? fuch_pkg::ST_RESV : fuch_pkg::ST_CHECK, "busy refusal");
    end
    unit_reserved <= 1'b0;
    run_cmd(fuch_pkg::OP_INQUIRY, 8'h00);
    check8(st, fuch_pkg::ST_GOOD, "inquiry while busy");
    sense_key(fuch_pkg::SK_NREADY);
    cert_addr <= {rnd8(), rnd8(), rnd8(), rnd8()};
    cert_defect <= 1'b1;
    @(posedge mclk);
    cert_defect <= 1'b0;
    repeat (2) @(posedge mclk);
    exp_cnt++;
    check8(defect_count, 8'(exp_cnt), "certification defect");
    check1(progress != 16'h0000, 1'b1, "progress reported");
    end_fmt(1'b0);
    $display("test busy done");
    // zero, one and two descriptors over the three formats; the last ends in failure
    for (int i = 0; i < 3; i++) begin
      build_list((i == 1) ? 8'h88 : 8'h80, i);
      run_cmd(fuch_pkg::OP_FORMAT, {3'h0, 2'b10, dlfs[i]});
      check8(st, fuch_pkg::ST_GOOD, "list format");
      exp_cnt = next_count(1'b0, exp_cnt, i);
      check8(defect_count, 8'(exp_cnt), "grown list adds");
      end_fmt(i == 2);
    end
    build_list(8'h80, 2);
    run_cmd(fuch_pkg::OP_FORMAT, 8'h18);
    check8(st, fuch_pkg::ST_GOOD, "complete list format");
    exp_cnt = next_count(1'b1, exp_cnt, 2);
    check8(defect_count, 8'(exp_cnt), "complete list replaces");
    end_fmt(1'b0);
    $display("test lists done");
    build_list(8'h10, 0);
    run_cmd(fuch_pkg::OP_FORMAT, 8'h10);
    check8(st, fuch_pkg::ST_CHECK, "unsupported option");
    check1(format_busy, 1'b0, "no busy on bad header");
    sense_key(fuch_pkg::SK_ILLEGAL);
    check8(defect_count, 8'(exp_cnt), "list kept");
    $display("test header done");
    bus(1'b0, fuch_pkg::A_IRQ, 32'h0, q);
    bus(1'b1, fuch_pkg::A_MASK, 32'h0, q);
    run_cmd(fuch_pkg::OP_INQUIRY, 8'h00);
    check1(irq, 1'b1, "irq raised");
    bus(1'b0, fuch_pkg::A_IRQ, 32'h0, q);
    check1(q[fuch_pkg::IRQ_DONE], 1'b1, "irq status");
    check1(irq, 1'b0, "irq cleared");
    bus(1'b1, fuch_pkg::A_MASK, 32'h3, q);
    run_cmd(fuch_pkg::OP_INQUIRY, 8'h00);
    check1(irq, 1'b0, "irq masked");
    bus(1'b0, fuch_pkg::A_IRQ, 32'h0, q);
    check1(q[fuch_pkg::IRQ_DONE], 1'b1, "masked status sticky");
    $display("test interrupt done");
    report_and_stop();
  end
endmodule : format_unit_command_handler_tb_top

// *** bench/fuch_checker.sv ***
// checker: concurrent assertions on the link between the two ends
module fuch_checker #(
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic       mclk,
  input wire logic       rst_n,
  // link
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic       cmd_ready,
  input wire logic       dout_req,
  input wire logic       din_valid,
  input wire logic [7:0] din_byte,
  input wire logic       stat_valid,
  input wire logic [7:0] stat_byte,
  // target state
  input wire logic       unit_reserved,
  input wire logic       extent_reserved,
  input wire logic       cert_defect,
  input wire logic       format_done,
  input wire logic       format_fail,
  input wire logic       format_busy,
  input wire logic [7:0] defect_count
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // command capture
  logic [2:0] cnt_q;
  logic [7:0] op_q;
  logic [7:0] b1_q;
  logic       busy_c_q;
  wire take = cmd_valid && cmd_ready;
  wire resv = unit_reserved || extent_reserved;
  wire is_fmt = op_q == fuch_pkg::OP_FORMAT;
  wire is_side = op_q == fuch_pkg::OP_INQUIRY || op_q == fuch_pkg::OP_REQ_SENSE;
  // busy is captured at the opcode so the status of the format itself is not judged as busy
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 3'h0;
      op_q <= 8'h00;
      b1_q <= 8'h00;
      busy_c_q <= 1'b0;
    end else if (stat_valid) begin
      cnt_q <= 3'h0;
    end else if (take) begin
      cnt_q <= cnt_q + 3'h1;
      if (cnt_q == 3'h0) op_q <= cmd_byte;
      if (cnt_q == 3'h0) busy_c_q <= format_busy;
      if (cnt_q == 3'h1) b1_q <= cmd_byte;
    end
  end
  // ==========================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_resv_refuse: assert property (stat_valid && is_fmt && resv && !busy_c_q |-> stat_byte == fuch_pkg::ST_RESV)
    else $error("format accepted on reserved unit");
  a_resv_no_busy: assert property (stat_valid && stat_byte == fuch_pkg::ST_RESV && !busy_c_q |=> !format_busy [*3])
    else $error("busy after refused format");
  a_busy_other: assert property (stat_valid && busy_c_q && !is_side
    |-> stat_byte == (resv ? fuch_pkg::ST_RESV : fuch_pkg::ST_CHECK))
    else $error("wrong status while formatting");
  a_inquiry_good: assert property (stat_valid && busy_c_q && op_q == fuch_pkg::OP_INQUIRY && !resv
    |-> stat_byte == fuch_pkg::ST_GOOD)
    else $error("inquiry refused while formatting");
  a_sense_nready: assert property (din_valid && busy_c_q && op_q == fuch_pkg::OP_REQ_SENSE
    |-> din_byte[7:4] == fuch_pkg::SK_NREADY)
    else $error("sense key not not-ready while formatting");
  a_dout_only_fdp: assert property (dout_req |-> is_fmt && b1_q[fuch_pkg::B1_FDP])
    else $error("data requested without format data");
  a_stat_pulse: assert property (stat_valid |=> !stat_valid)
    else $error("status longer than one cycle");
  a_busy_hold: assert property (format_busy && !format_done && !format_fail |=> format_busy)
    else $error("busy dropped early");
  a_busy_clear: assert property (format_busy && (format_done || format_fail) |=> !format_busy)
    else $error("busy not cleared");
  a_cert_add: assert property (cert_defect && format_busy && defect_count < DEPTH
    |=> defect_count == $past(defect_count) + 8'h01)
    else $error("certification defect not added");
  c_resv: cover property (stat_valid && stat_byte == fuch_pkg::ST_RESV);
  c_dout: cover property (dout_req);
  c_busy_sense: cover property (din_valid && busy_c_q);
  c_done: cover property ($fell(format_busy));
endmodule : fuch_checker

// *** hw/fuch_defect_list.sv ***
// grown defect list store with merge and clear
module fuch_defect_list #(
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // control
  input  wire logic        clear,
  input  wire logic        add,
  input  wire logic [31:0] addr,
  // status
  output logic [7:0]       count,
  output logic             full
);
  logic [31:0] mem [DEPTH];
  logic [7:0]  cnt_q;
  assign count = cnt_q;
  assign full  = (cnt_q == 8'(DEPTH));
  // the primary list is never held here, so it cannot be altered
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
    end else if (clear) begin
      cnt_q <= 8'h00;
    end else if (add && !full) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  always_ff @(posedge mclk) begin
    if (add && !full && !clear) begin
      mem[cnt_q[$clog2(DEPTH)-1:0]] <= addr;
    end
  end
endmodule : fuch_defect_list

// *** hw/fuch_if.sv ***
// interface: byte-wide command/data/status link between initiator and target
interface fuch_if;
  logic       cmd_valid;
  logic [7:0] cmd_byte;
  logic       cmd_ready;
  logic       dout_req;
  logic       dout_valid;
  logic [7:0] dout_byte;
  logic       din_valid;
  logic [7:0] din_byte;
  logic       stat_valid;
  logic [7:0] stat_byte;
  modport target (input cmd_valid, cmd_byte, dout_valid, dout_byte,
                  output cmd_ready, dout_req, din_valid, din_byte, stat_valid, stat_byte);
  modport initiator (output cmd_valid, cmd_byte, dout_valid, dout_byte,
                     input cmd_ready, dout_req, din_valid, din_byte, stat_valid, stat_byte);
endinterface : fuch_if

// *** hw/fuch_initiator.sv ***
// initiator end: Avalon-MM controlled sender of commands and parameter data
module fuch_initiator (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // interrupt
  output logic             irq,
  // link
  fuch_if.initiator        lnk
);
  logic [7:0]  cdb_q [fuch_pkg::CDB_LEN];
  logic [2:0]  cidx_q;
  logic        sending_q;
  logic [7:0]  dout_q;
  logic        dfull_q;
  logic [7:0]  stat_q, sense_q;
  logic [1:0]  irq_q, mask_q;
  logic [31:0] rd_q;
  logic        ack_q;
  // ==================================================
  // bus decode
  wire acc     = (avs_read | avs_write) & ~ack_q;
  wire wr      = avs_write & ack_q;
  wire rd      = avs_read & ack_q;
  wire sel_ctl = (avs_address == fuch_pkg::A_CTRL);
  wire sel_cdb = (avs_address == fuch_pkg::A_CDB);
  wire sel_do  = (avs_address == fuch_pkg::A_DOUT);
  wire sel_irq = (avs_address == fuch_pkg::A_IRQ);
  wire sel_msk = (avs_address == fuch_pkg::A_MASK);
  wire [31:0] rmux = (avs_address == fuch_pkg::A_STAT)  ? {23'h0, dfull_q, stat_q} :
                     sel_irq                           ? {30'h0, irq_q} :
                     sel_msk                           ? {30'h0, mask_q} :
                     (avs_address == fuch_pkg::A_SENSE) ? {24'h0, sense_q} : 32'h0000_0000;
  wire ev_done = lnk.stat_valid;
  wire ev_dreq = lnk.dout_req & ~dfull_q;
  // one wait cycle per access; mode parameters are software's to set first
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign avs_readdata    = rd_q;
  // a set mask bit silences its event; the status bit still sticks
  assign irq             = |(irq_q & ~mask_q);
  assign lnk.cmd_valid   = sending_q;
  assign lnk.cmd_byte    = cdb_q[cidx_q];
  assign lnk.dout_valid  = dfull_q & lnk.dout_req;
  assign lnk.dout_byte   = dout_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rd_q <= 32'h0000_0000;
      cidx_q <= 3'h0;
      sending_q <= 1'b0;
      dout_q <= 8'h00;
      dfull_q <= 1'b0;
      stat_q <= 8'h00;
      sense_q <= 8'h00;
      irq_q <= 2'h0;
      mask_q <= 2'h0;
      for (int i = 0; i < fuch_pkg::CDB_LEN; i++) begin
        cdb_q[i] <= 8'h00;
      end
    end else begin
      ack_q <= acc;
      if (acc) begin
        rd_q <= rmux;
      end
      // clear only what the read returned; a new event wins over the clear
      irq_q <= ((rd && sel_irq) ? (irq_q & ~rd_q[1:0]) : irq_q) | {ev_dreq, ev_done};
      if (wr && sel_msk) begin
        mask_q <= avs_writedata[1:0];
      end
      if (wr && sel_cdb) begin
        cdb_q[avs_writedata[10:8]] <= avs_writedata[7:0];
      end
      if (wr && sel_ctl && avs_writedata[fuch_pkg::CTRL_GO]) begin
        sending_q <= 1'b1;
        cidx_q <= 3'h0;
      end else if (sending_q && lnk.cmd_ready) begin
        cidx_q <= cidx_q + 3'h1;
        if (cidx_q == 3'(fuch_pkg::CDB_LEN - 1)) begin
          sending_q <= 1'b0;
          cidx_q <= 3'h0;
        end
      end
      if (wr && sel_do) begin
        dout_q <= avs_writedata[7:0];
        dfull_q <= 1'b1;
      end else if (lnk.dout_valid) begin
        dfull_q <= 1'b0;
      end
      if (lnk.stat_valid) begin
        stat_q <= lnk.stat_byte;
      end
      if (lnk.din_valid) begin
        sense_q <= lnk.din_byte;
      end
    end
  end
endmodule : fuch_initiator

// *** hw/fuch_pkg.sv ***
// package: constants and register map for the format command handler
package fuch_pkg;
  // ==================================================
  // command block
  localparam logic [7:0] OP_FORMAT    = 8'h04;
  localparam logic [7:0] OP_INQUIRY   = 8'h12;
  localparam logic [7:0] OP_REQ_SENSE = 8'h03;
  localparam int         CDB_LEN      = 6;
  localparam int         B1_FDP       = 4;
  localparam int         B1_CMPL      = 3;
  localparam int         HDR_LEN      = 4;
  localparam int         PAT_LEN      = 4;
  localparam int         DESC_LEN     = 8;
  // ==================================================
  // header byte 1 bits
  localparam int H_OPT_VALID  = 7;
  localparam int H_NO_PRIMARY = 6;
  localparam int H_NO_CERT    = 5;
  localparam int H_STOP_FMT   = 4;
  localparam int H_INIT_PAT   = 3;
  localparam logic [7:0] H_SUPPORTED = 8'hE8;
  // ==================================================
  // defect list formats
  localparam logic [2:0] DLF_BLOCK = 3'h0;
  localparam logic [2:0] DLF_BFI   = 3'h4;
  localparam logic [2:0] DLF_PHYS  = 3'h5;
  // ==================================================
  // status and sense
  localparam logic [7:0] ST_GOOD  = 8'h00;
  localparam logic [7:0] ST_CHECK = 8'h02;
  localparam logic [7:0] ST_RESV  = 8'h18;
  localparam logic [3:0] SK_NONE  = 4'h0;
  localparam logic [3:0] SK_NREADY = 4'h2;
  localparam logic [3:0] SK_ILLEGAL = 4'h5;
  localparam logic [7:0] ASC_NREADY = 8'h04;
  localparam logic [7:0] ASCQ_FMT   = 8'h04;
  localparam logic [7:0] ASC_INVPL  = 8'h26;
  localparam logic [7:0] ASCQ_NONE  = 8'h00;
  // ==================================================
  // register map of the initiator controller (word addresses, one per 32-bit register)
  localparam logic [3:0] A_CTRL   = 4'h0;
  localparam logic [3:0] A_CDB    = 4'h1;
  localparam logic [3:0] A_DOUT   = 4'h2;
  localparam logic [3:0] A_STAT   = 4'h3;
  localparam logic [3:0] A_IRQ    = 4'h4;
  localparam logic [3:0] A_MASK   = 4'h5;
  localparam logic [3:0] A_SENSE  = 4'h6;
  localparam int         CTRL_GO  = 0;
  localparam int         IRQ_DONE = 0;
  localparam int         IRQ_DREQ = 1;
  localparam int         FMT_TICKS = 16;
endpackage : fuch_pkg

// *** hw/fuch_target.sv ***
// target end: command decode, format state, parameter list parse
module fuch_target #(
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // link
  fuch_if.target           lnk,
  // unit state
  input  wire logic        unit_reserved,
  input  wire logic        extent_reserved,
  input  wire logic        cert_defect,
  input  wire logic [31:0] cert_addr,
  input  wire logic        format_done,
  input  wire logic        format_fail,
  // status
  output logic             format_busy,
  output logic [15:0]      progress,
  output logic [7:0]       defect_count
);
  typedef enum logic [2:0] {S_CDB, S_HDR, S_PAT, S_DESC, S_STAT, S_DATA} fuch_tst_t;
  fuch_tst_t   st_q;
  logic [7:0]  cdb_q [fuch_pkg::CDB_LEN];
  logic [2:0]  idx_q;
  logic [15:0] len_q, cnt_q;
  logic [7:0]  hb1_q;
  logic [31:0] dacc_q;
  logic [7:0]  stat_q;
  logic        busy_q;
  logic [3:0]  sk_q;
  logic [7:0]  asc_q, ascq_q;
  logic [15:0] prog_q;
  logic        clr, add_d;
  logic [31:0] add_addr;
  logic        tick;
  // ==================================================
  // decode
  wire        cdb_last = (idx_q == 3'(fuch_pkg::CDB_LEN - 1));
  wire [7:0]  op       = cdb_q[0];
  wire        fdp      = cdb_q[1][fuch_pkg::B1_FDP];
  wire        cmpl     = cdb_q[1][fuch_pkg::B1_CMPL];
  wire [2:0]  dlf      = cdb_q[1][2:0];
  wire        resv     = unit_reserved | extent_reserved;
  wire        dlf_ok   = (dlf == fuch_pkg::DLF_BLOCK) | (dlf == fuch_pkg::DLF_BFI) |
                         (dlf == fuch_pkg::DLF_PHYS);
  wire        take     = lnk.dout_valid;
  assign lnk.cmd_ready  = (st_q == S_CDB);
  assign lnk.dout_req   = (st_q == S_HDR) | (st_q == S_PAT) | (st_q == S_DESC);
  assign lnk.stat_valid = (st_q == S_STAT);
  assign lnk.stat_byte  = stat_q;
  assign lnk.din_valid  = (st_q == S_DATA);
  assign lnk.din_byte   = {sk_q, 4'h0} ^ 8'h00;
  assign format_busy    = busy_q;
  assign progress       = prog_q;
  fuch_defect_list #(.DEPTH(DEPTH)) u_glist (
    .mclk  (mclk),
    .rst_n (rst_n),
    .clear (clr),
    .add   (add_d),
    .addr  (add_addr),
    .count (defect_count),
    .full  ()
  );
  // certification defects share the port; descriptor adds take priority
  // the defect address is the last four bytes of each eight-byte descriptor
  wire        desc_end = (st_q == S_DESC) && take && (cnt_q[2:0] == 3'(fuch_pkg::DESC_LEN - 1));
  assign add_addr = desc_end ? {dacc_q[23:0], lnk.dout_byte} : cert_addr;
  assign add_d    = desc_end | (busy_q & cert_defect);
  // saturating, so a long format never shows progress wrapping back to zero
  assign tick     = busy_q & (prog_q != 16'hFFFF);
  // ==================================================
  // main sequencer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= S_CDB;
      idx_q <= 3'h0;
      len_q <= 16'h0000;
      cnt_q <= 16'h0000;
      hb1_q <= 8'h00;
      dacc_q <= 32'h0000_0000;
      stat_q <= fuch_pkg::ST_GOOD;
      busy_q <= 1'b0;
      sk_q <= fuch_pkg::SK_NONE;
      asc_q <= 8'h00;
      ascq_q <= 8'h00;
      prog_q <= 16'h0000;
      clr <= 1'b0;
      for (int i = 0; i < fuch_pkg::CDB_LEN; i++) begin
        cdb_q[i] <= 8'h00;
      end
    end else begin
      clr <= 1'b0;
      if (tick) begin
        prog_q <= prog_q + 16'h0001;
      end
      if (busy_q && (format_done || format_fail)) begin
        busy_q <= 1'b0;
        // a failure leaves not-ready for the next sense; success drops the stale key
        sk_q   <= format_fail ? fuch_pkg::SK_NREADY : fuch_pkg::SK_NONE;
      end
      case (st_q)
        S_CDB: begin
          if (lnk.cmd_valid) begin
            cdb_q[idx_q] <= lnk.cmd_byte;
            idx_q <= cdb_last ? 3'h0 : idx_q + 3'h1;
            if (idx_q == 3'h0) begin
              cdb_q[1] <= 8'h00;
            end
            if (cdb_last) begin
              st_q <= S_STAT;
              stat_q <= fuch_pkg::ST_GOOD;
              // sense and inquiry are decoded first: formatting never refuses them
              if (op == fuch_pkg::OP_INQUIRY) begin
                st_q <= S_DATA;
              end else if (op == fuch_pkg::OP_REQ_SENSE) begin
                st_q <= S_DATA;
                if (busy_q) begin
                  sk_q <= fuch_pkg::SK_NREADY;
                  asc_q <= fuch_pkg::ASC_NREADY;
                  ascq_q <= fuch_pkg::ASCQ_FMT;
                end
              end else if (resv) begin
                stat_q <= fuch_pkg::ST_RESV;
              end else if (busy_q) begin
                stat_q <= fuch_pkg::ST_CHECK;
              end else if (op == fuch_pkg::OP_FORMAT) begin
                if (!dlf_ok) begin
                  stat_q <= fuch_pkg::ST_CHECK;
                  sk_q <= fuch_pkg::SK_ILLEGAL;
                end else if (fdp) begin
                  st_q <= S_HDR;
                  cnt_q <= 16'h0000;
                end else begin
                  busy_q <= 1'b1;
                  prog_q <= 16'h0000;
                  clr <= cmpl;
                end
              end
            end
          end
        end
        S_HDR: begin
          if (take) begin
            cnt_q <= cnt_q + 16'h0001;
            if (cnt_q == 16'h0001) begin
              hb1_q <= lnk.dout_byte;
            end
            if (cnt_q == 16'h0002) begin
              len_q[15:8] <= lnk.dout_byte;
            end
            if (cnt_q == 16'h0003) begin
              len_q[7:0] <= lnk.dout_byte;
              cnt_q <= 16'h0000;
              st_q <= hb1_q[fuch_pkg::H_INIT_PAT] ? S_PAT : S_DESC;
              // options are judged after the length bytes, so the header is always drained
              if ((hb1_q & ~fuch_pkg::H_SUPPORTED) != 8'h00) begin
                st_q <= S_STAT;
                stat_q <= fuch_pkg::ST_CHECK;
                sk_q <= fuch_pkg::SK_ILLEGAL;
                asc_q <= fuch_pkg::ASC_INVPL;
                ascq_q <= fuch_pkg::ASCQ_NONE;
              end else if (!hb1_q[fuch_pkg::H_INIT_PAT] && {len_q[15:8], lnk.dout_byte} == 16'h0000) begin
                st_q <= S_STAT;
                busy_q <= 1'b1;
                prog_q <= 16'h0000;
                clr <= cmpl;
              end else begin
                clr <= cmpl;
              end
            end
          end
        end
        S_PAT: begin
          if (take) begin
            cnt_q <= cnt_q + 16'h0001;
            if (cnt_q == 16'(fuch_pkg::PAT_LEN - 1)) begin
              cnt_q <= 16'h0000;
              st_q <= (len_q == 16'h0000) ? S_STAT : S_DESC;
              busy_q <= (len_q == 16'h0000);
              prog_q <= 16'h0000;
            end
          end
        end
        S_DESC: begin
          if (take) begin
            dacc_q <= {dacc_q[23:0], lnk.dout_byte};
            cnt_q <= cnt_q + 16'h0001;
            if (cnt_q == len_q - 16'h0001) begin
              st_q <= S_STAT;
              busy_q <= 1'b1;
              prog_q <= 16'h0000;
            end
          end
        end
        S_STAT: begin
          st_q <= S_CDB;
        end
        default: begin
          st_q <= S_STAT;
          if (!busy_q) begin
            sk_q <= fuch_pkg::SK_NONE;
          end
        end
      endcase
    end
  end
endmodule : fuch_target
